// *** seclp_pkg.sv ***
package seclp_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] SECLP_ADDR_BWS   = 8'h00;
  localparam logic [7:0] SECLP_ADDR_RSS   = 8'h01;
  localparam logic [7:0] SECLP_ADDR_BFCC  = 8'h02;

  // Field positions.
  localparam int SECLP_BW_BIT    = 1;
  localparam int SECLP_BREAK_FLAG_CLEAR_ENABLE_BIT  = 7;
  localparam int SECLP_RS_LVI    = 1;
  localparam int SECLP_RS_BAD_FETCH_ADDRESS_FLAG   = 3;
  localparam int SECLP_RS_BAD_OPCODE_FLAG   = 4;
  localparam int SECLP_RS_WDOG   = 5;
  localparam int SECLP_RS_PIN    = 6;
  localparam int SECLP_RS_POR    = 7;

  // Reset values.
  localparam logic [7:0] SECLP_BWS_RST   = 8'h00;
  localparam logic [7:0] SECLP_RSS_RST   = 8'h80;
  localparam logic [7:0] SECLP_BFCC_RST  = 8'h00;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int         SECLP_CNT_W       = 12;
  localparam int         SECLP_REC_LONG    = 4096;
  localparam int         SECLP_REC_SHORT   = 32;
  localparam logic [11:0] SECLP_REC_SHORT_C = 12'h01F;

  // Vector selection toward the core.
  localparam logic [1:0] SECLP_VEC_NONE = 2'h0;
  localparam logic [1:0] SECLP_VEC_RST  = 2'h1;
  localparam logic [1:0] SECLP_VEC_SWI  = 2'h2;
  localparam logic [1:0] SECLP_VEC_HW   = 2'h3;

  typedef enum logic [2:0] {
    SECLP_RUN,
    SECLP_WAIT,
    SECLP_STOP,
    SECLP_RECOVER,
    SECLP_BREAK
  } seclp_mode_t;

  // Register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } seclp_bus_t;

  // Reset cause reports, one-cycle pulses.
  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic bad_opcode_flag;
    logic bad_fetch_address_flag;
    logic low_voltage_flag;
  } seclp_rst_src_t;

endpackage

// *** seclp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module seclp_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  import seclp_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } seclp_sync_st_t;

  seclp_sync_st_t st_r;
  seclp_sync_st_t st_nxt;

  // The second stage alone reads the first.
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // Synchroniser flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule
`default_nettype wire

// *** seclp_rec_cnt.sv ***
`timescale 1ns/1ns
`default_nettype none
module seclp_rec_cnt (
  input  wire logic        crystal_clock,
  input  wire logic        rst_n,
  input  wire logic        hold,
  input  wire logic        short_sel,
  output logic             done
);
  import seclp_pkg::*;

  typedef struct packed {
    logic [SECLP_CNT_W-1:0] cnt;
    logic                   wrap;
    logic                   done;
  } seclp_cnt_st_t;

  seclp_cnt_st_t st_r;
  seclp_cnt_st_t st_nxt;

  // Counter held clear while hold is high, then counts the recovery period.
  always_comb begin
    st_nxt = st_r;
    if (hold) begin
      st_nxt = '0;
    end else begin
      {st_nxt.wrap, st_nxt.cnt} = {1'b0, st_r.cnt} + 13'h0001;
      if (st_r.wrap) begin
        st_nxt.wrap = 1'b1;
      end
      if (short_sel) begin
        st_nxt.done = st_r.done | (st_r.cnt == SECLP_REC_SHORT_C);
      end else begin
        st_nxt.done = st_r.done | (st_r.cnt == 12'hFFF);
      end
    end
  end

  // Advances on the falling crystal edge.
  always_ff @(negedge crystal_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule
`default_nettype wire

// *** seclp_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module seclp_top (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     crystal_clock,
  input  wire seclp_pkg::seclp_bus_t    bus,
  output logic [7:0]                    rdata,
  input  wire seclp_pkg::seclp_rst_src_t rst_src,
  input  wire logic                     instr_end,
  input  wire logic                     soft_interrupt_instr,
  input  wire logic                     wait_instr,
  input  wire logic                     halt_instr,
  input  wire logic                     irq_pending,
  input  wire logic                     mask_bit,
  input  wire logic                     break_req_pin,
  input  wire logic                     break_exit,
  input  wire logic                     short_recovery_select,
  input  wire logic                     watchdog_disable,
  input  wire logic                     flag_clear_req,
  output logic                          take_exception,
  output logic [1:0]                    vector_sel,
  output logic                          stack_pc_minus_one,
  output logic                          clear_mask,
  output logic                          cpu_clk_en,
  output logic                          periph_clk_en,
  output logic                          base_clock_out_en,
  output logic                          crystal_clock_out_en,
  output logic                          watchdog_run,
  output logic                          break_module_en,
  output logic                          flag_clear_allow,
  output logic                          in_break
);
  import seclp_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    seclp_mode_t mode;
    logic        bw;
    logic        break_flag_clear_enable;
    logic [5:0]  rss;
    logic [7:0]  rdata;
    logic        take;
    logic [1:0]  vec;
    logic        pcm1;
    logic        clr_mask;
    logic        cpu_en;
    logic        per_en;
    logic        clk_en;
    logic        wdog;
    logic        brk_en;
    logic        fca;
    logic        in_brk;
    logic        rec_hold;
  } seclp_st_t;

  seclp_st_t st_r;
  seclp_st_t st_nxt;
  logic      brk_s;
  logic      rec_done_x;
  logic      rec_done_s;
  logic      any_rst;

  // Reading a register, undocumented bits zero.
  function automatic logic [7:0] seclp_read(input logic [7:0] a, input seclp_st_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      SECLP_ADDR_BWS:  v[SECLP_BW_BIT] = s.bw;
      SECLP_ADDR_RSS: begin
        // Each cause lands on its own bit; the reserved bits stay zero.
        v[SECLP_RS_POR]  = s.rss[5];
        v[SECLP_RS_PIN]  = s.rss[4];
        v[SECLP_RS_WDOG] = s.rss[3];
        v[SECLP_RS_BAD_OPCODE_FLAG] = s.rss[2];
        v[SECLP_RS_BAD_FETCH_ADDRESS_FLAG] = s.rss[1];
        v[SECLP_RS_LVI]  = s.rss[0];
      end
      SECLP_ADDR_BFCC: v[SECLP_BREAK_FLAG_CLEAR_ENABLE_BIT] = s.break_flag_clear_enable;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Input crossing.
  // ****************************************************************
  seclp_sync u_brk_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (break_req_pin),
    .q       (brk_s)
  );

  seclp_rec_cnt u_rec (
    .crystal_clock (crystal_clock),
    .rst_n         (rst_n),
    .hold          (st_r.rec_hold),
    .short_sel     (short_recovery_select),
    .done          (rec_done_x)
  );

  seclp_sync u_rec_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (rec_done_x),
    .q       (rec_done_s)
  );

  // Any reset cause report.
  assign any_rst = |rst_src;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    st_nxt          = st_r;
    st_nxt.take     = 1'b0;
    st_nxt.vec      = SECLP_VEC_NONE;
    st_nxt.pcm1     = 1'b0;
    st_nxt.clr_mask = 1'b0;
    st_nxt.rdata    = 8'h00;

    // Register reads with one-cycle latency.
    if (bus.rd) begin
      st_nxt.rdata = seclp_read(bus.addr, st_r);
      if (bus.addr == SECLP_ADDR_RSS) begin
        st_nxt.rss = 6'h00;
      end
    end

    // Register writes; only documented bits are stored.
    if (bus.wr) begin
      if (bus.addr == SECLP_ADDR_BWS && !bus.wdata[SECLP_BW_BIT]) begin
        st_nxt.bw = 1'b0;
      end
      if (bus.addr == SECLP_ADDR_BFCC) begin
        st_nxt.break_flag_clear_enable = bus.wdata[SECLP_BREAK_FLAG_CLEAR_ENABLE_BIT];
      end
    end

    // Mode sequencing.
    case (st_r.mode)
      SECLP_RUN: begin
        if (brk_s && instr_end) begin
          st_nxt.mode = SECLP_BREAK;
          st_nxt.take = 1'b1;
          st_nxt.vec  = SECLP_VEC_SWI;
        end else if (soft_interrupt_instr) begin
          st_nxt.take = 1'b1;
          st_nxt.vec  = SECLP_VEC_SWI;
          st_nxt.pcm1 = 1'b0;
        end else if (irq_pending && !mask_bit && instr_end) begin
          st_nxt.take = 1'b1;
          st_nxt.vec  = SECLP_VEC_HW;
          st_nxt.pcm1 = 1'b1;
        end else if (wait_instr) begin
          st_nxt.mode     = SECLP_WAIT;
          st_nxt.clr_mask = 1'b1;
          st_nxt.cpu_en   = 1'b0;
        end else if (halt_instr) begin
          st_nxt.mode     = SECLP_STOP;
          st_nxt.clr_mask = 1'b1;
          st_nxt.cpu_en   = 1'b0;
          st_nxt.per_en   = 1'b0;
          st_nxt.clk_en   = 1'b0;
          st_nxt.brk_en   = 1'b0;
          st_nxt.rec_hold = 1'b1;
        end
      end
      SECLP_WAIT: begin
        if (brk_s) begin
          st_nxt.bw     = 1'b1;
          st_nxt.mode   = SECLP_BREAK;
          st_nxt.cpu_en = 1'b1;
          st_nxt.take   = 1'b1;
          st_nxt.vec    = SECLP_VEC_SWI;
        end else if (irq_pending) begin
          st_nxt.mode   = SECLP_RUN;
          st_nxt.cpu_en = 1'b1;
          st_nxt.take   = 1'b1;
          st_nxt.vec    = SECLP_VEC_HW;
          st_nxt.pcm1   = 1'b1;
        end
      end
      SECLP_STOP: begin
        if (irq_pending) begin
          st_nxt.mode     = SECLP_RECOVER;
          st_nxt.rec_hold = 1'b0;
        end
      end
      SECLP_RECOVER: begin
        if (rec_done_s) begin
          st_nxt.mode     = SECLP_RUN;
          st_nxt.cpu_en   = 1'b1;
          st_nxt.per_en   = 1'b1;
          st_nxt.clk_en   = 1'b1;
          st_nxt.brk_en   = 1'b1;
          st_nxt.rec_hold = 1'b1;
          st_nxt.take     = 1'b1;
          st_nxt.vec      = SECLP_VEC_HW;
          st_nxt.pcm1     = 1'b1;
        end
      end
      SECLP_BREAK: begin
        if (break_exit) begin
          st_nxt.mode = SECLP_RUN;
        end
      end
      default: st_nxt.mode = SECLP_RUN;
    endcase

    // Watchdog keeps running unless disabled; stopped with clocks in stop.
    st_nxt.wdog = !watchdog_disable && st_nxt.per_en;

    // Clearing is gated only in break; a gated request is simply dropped.
    st_nxt.in_brk = (st_nxt.mode == SECLP_BREAK);
    st_nxt.fca    = flag_clear_req && (!st_nxt.in_brk || st_r.break_flag_clear_enable);

    // Reset wins over every interrupt and mode.
    if (any_rst) begin
      st_nxt.mode     = SECLP_RUN;
      st_nxt.take     = 1'b1;
      st_nxt.vec      = SECLP_VEC_RST;
      st_nxt.pcm1     = 1'b0;
      st_nxt.bw       = 1'b0;
      st_nxt.break_flag_clear_enable     = 1'b0;
      st_nxt.cpu_en   = 1'b1;
      st_nxt.per_en   = 1'b1;
      st_nxt.clk_en   = 1'b1;
      st_nxt.brk_en   = 1'b1;
      st_nxt.rec_hold = 1'b1;
      st_nxt.in_brk   = 1'b0;
      st_nxt.fca      = 1'b0;
      if (rst_src.por) begin
        st_nxt.rss = 6'h20;
      end else begin
        st_nxt.rss = {1'b0, rst_src.pin,
                      !rst_src.pin && rst_src.wdog,
                      !rst_src.pin && !rst_src.wdog && rst_src.bad_opcode_flag,
                      !rst_src.pin && !rst_src.wdog && !rst_src.bad_opcode_flag && rst_src.bad_fetch_address_flag,
                      !rst_src.pin && !rst_src.wdog && !rst_src.bad_opcode_flag && !rst_src.bad_fetch_address_flag
                        && rst_src.low_voltage_flag};
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.mode     <= SECLP_RUN;
      st_r.rss      <= SECLP_RSS_RST[7:2];
      st_r.cpu_en   <= 1'b1;
      st_r.per_en   <= 1'b1;
      st_r.clk_en   <= 1'b1;
      st_r.brk_en   <= 1'b1;
      st_r.rec_hold <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops.
  assign rdata                = st_r.rdata;
  assign take_exception       = st_r.take;
  assign vector_sel           = st_r.vec;
  assign stack_pc_minus_one   = st_r.pcm1;
  assign clear_mask           = st_r.clr_mask;
  assign cpu_clk_en           = st_r.cpu_en;
  assign periph_clk_en        = st_r.per_en;
  assign base_clock_out_en    = st_r.clk_en;
  assign crystal_clock_out_en = st_r.clk_en;
  assign watchdog_run         = st_r.wdog;
  assign break_module_en      = st_r.brk_en;
  assign flag_clear_allow     = st_r.fca;
  assign in_break             = st_r.in_brk;
endmodule
`default_nettype wire

// *** seclp_top_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Port checker for the exception and low-power controller.
// ****************************************************************
module seclp_chk (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire seclp_pkg::seclp_bus_t   bus,
  input wire logic [7:0]              rdata,
  input wire seclp_pkg::seclp_rst_src_t rst_src,
  input wire logic                    soft_interrupt_instr,
  input wire logic                    mask_bit,
  input wire logic                    take_exception,
  input wire logic [1:0]              vector_sel,
  input wire logic                    stack_pc_minus_one,
  input wire logic                    cpu_clk_en,
  input wire logic                    periph_clk_en,
  input wire logic                    base_clock_out_en,
  input wire logic                    crystal_clock_out_en,
  input wire logic                    watchdog_disable,
  input wire logic                    watchdog_run,
  input wire logic                    in_break
);
  import seclp_pkg::*;
  logic rd_rss;

  // A read of the reset-source register with no cause report beside it.
  assign rd_rss = bus.rd && bus.addr == SECLP_ADDR_RSS && rst_src == '0;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Register read answers and their spare bits.
  chk_unmapped_zero: assert property (
    bus.rd && bus.addr > SECLP_ADDR_BFCC |=> rdata == 8'h00)
    else $error("Unmapped read returned nonzero data.");
  chk_bfcc_spare: assert property (
    bus.rd && bus.addr == SECLP_ADDR_BFCC |=> rdata[6:0] == 7'h00)
    else $error("Spare clear-control bits read nonzero.");
  chk_bws_spare: assert property (
    bus.rd && bus.addr == SECLP_ADDR_BWS |=> (rdata & 8'hFD) == 8'h00)
    else $error("Spare break-wait bits read nonzero.");
  chk_rss_clear: assert property (
    rd_rss ##1 rd_rss |=> rdata == 8'h00)
    else $error("Reset-source flags survived a read.");

  // Exception entry.
  chk_soft_take: assert property (
    $rose(soft_interrupt_instr) && mask_bit && cpu_clk_en && !in_break
    |-> ##[1:4] take_exception && vector_sel == SECLP_VEC_SWI)
    else $error("Masked soft interrupt was not taken.");
  chk_stack_kind: assert property (
    take_exception && vector_sel[1] |-> stack_pc_minus_one == vector_sel[0])
    else $error("Stacked return address kind is wrong.");

  // Low-power clock gating.
  chk_wait_periph: assert property (
    !cpu_clk_en && base_clock_out_en |-> periph_clk_en)
    else $error("Peripheral clocks stopped in wait.");
  chk_wdog_wait: assert property (
    !cpu_clk_en && base_clock_out_en && !watchdog_disable |-> watchdog_run)
    else $error("Watchdog stopped in wait.");
  chk_stop_gate: assert property (
    !base_clock_out_en |-> !crystal_clock_out_en && !cpu_clk_en)
    else $error("Clock outputs not gated in stop.");
endmodule

bind seclp_top seclp_chk i_seclp_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .rst_src(rst_src),
  .soft_interrupt_instr(soft_interrupt_instr), .mask_bit(mask_bit),
  .take_exception(take_exception), .vector_sel(vector_sel),
  .stack_pc_minus_one(stack_pc_minus_one), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .base_clock_out_en(base_clock_out_en),
  .crystal_clock_out_en(crystal_clock_out_en), .watchdog_disable(watchdog_disable),
  .watchdog_run(watchdog_run), .in_break(in_break));
`default_nettype wire

// *** seclp_periph.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Peripheral status flag that obeys the clear grant.
// ****************************************************************
module seclp_periph (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic set_ev,
  input  wire logic clr_ok,
  output logic      flag_r
);
  // An event sets the flag; only a granted clear may drop it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (set_ev) begin
      flag_r <= 1'b1;
    end else if (clr_ok) begin
      flag_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** seclp_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module seclp_top_bench;
  import seclp_pkg::*;
  // ****************************************************************
  // Stimulus, reference model and checks.
  // ****************************************************************
  logic sys_clk = 1'b0, rst_n = 1'b0, xclk = 1'b0, iend = 1'b0, soft_i = 1'b0;
  logic wait_i = 1'b0, halt_i = 1'b0, irq = 1'b0, mask = 1'b0, brk = 1'b0;
  logic bexit = 1'b0, ssr = 1'b0, wdis = 1'b0, creq = 1'b0, pset = 1'b0;
  logic take, stk, cm, cpu_en, per_en, base_en, xo_en, wd_run, brk_en, allow, inb, pflag;
  logic [7:0] rdata, a, d;
  logic [1:0] vsel;
  seclp_bus_t bus = '0;
  seclp_rst_src_t rst_src = '0;
  int miscompares = 0, checked = 0, k, c0, cm_cnt = 0, rss = 'h80, bws = 0, bfcc = 0;
  integer seed = 32'h69c1;

  seclp_top i_seclp_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .crystal_clock(xclk), .bus(bus), .rdata(rdata),
    .rst_src(rst_src), .instr_end(iend), .soft_interrupt_instr(soft_i), .wait_instr(wait_i),
    .halt_instr(halt_i), .irq_pending(irq), .mask_bit(mask), .break_req_pin(brk),
    .break_exit(bexit), .short_recovery_select(ssr), .watchdog_disable(wdis),
    .flag_clear_req(creq), .take_exception(take), .vector_sel(vsel),
    .stack_pc_minus_one(stk), .clear_mask(cm), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
    .base_clock_out_en(base_en), .crystal_clock_out_en(xo_en), .watchdog_run(wd_run),
    .break_module_en(brk_en), .flag_clear_allow(allow), .in_break(inb));
  seclp_periph i_seclp_periph (.sys_clk(sys_clk), .rst_n(rst_n), .set_ev(pset),
    .clr_ok(allow), .flag_r(pflag));

  // System clock at 10 MHz and an unrelated 4 MHz crystal clock.
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    forever #125 xclk = ~xclk;
  end
  // Counts mask-clear pulses sent to the core.
  always @(posedge sys_clk) begin
    if (cm === 1'b1) cm_cnt++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge sys_clk);
    bus.addr <= ad;
    bus.wdata <= dt;
    bus.wr <= 1'b1;
    @(posedge sys_clk) bus.wr <= 1'b0;
    if (ad == SECLP_ADDR_BFCC) bfcc = dt & 8'h80;
    if (ad == SECLP_ADDR_BWS && !dt[1]) bws = 0;
  endtask
  task automatic rd(input logic [7:0] ad);
    int e;
    e = ad == SECLP_ADDR_BWS ? bws : ad == SECLP_ADDR_BFCC ? bfcc : 0;
    if (ad == SECLP_ADDR_RSS) e = rss;
    if (ad == SECLP_ADDR_RSS) rss = 0;
    @(posedge sys_clk);
    bus.addr <= ad;
    bus.rd <= 1'b1;
    @(posedge sys_clk) bus.rd <= 1'b0;
    @(posedge sys_clk) chk(rdata, e[7:0]);
  endtask
  task automatic wait_take();
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (take !== 1'b1 && k < 12000);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The tests need about 10600 cycles; a hang is cut at more than twice that.
  initial begin
    #(30000 * 100);
    miscompares++;
    give_verdict();
  end

  // Main sequence of tests.
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus.addr <= SECLP_ADDR_RSS;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk) bus.rd <= 1'b0;
    chk(rdata, 8'h80);
    @(posedge sys_clk) chk(rdata, 8'h00);
    rss = 0;
    for (int i = 0; i < 24; i++) begin
      a = 8'($random(seed) & 7);
      d = 8'($random(seed));
      wr(a, d);
      rd(a);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk) rst_src <= seclp_rst_src_t'(6'(1 << ((i + 1) % 6)));
      @(posedge sys_clk) rst_src <= seclp_rst_src_t'(6'(1 << i));
      @(posedge sys_clk) rst_src <= '0;
      rss = (i == 0) ? 'h02 : (1 << (i + 2));
      rd(SECLP_ADDR_RSS);
    end
    $display("Register test done");
    mask <= 1'b1;
    @(posedge sys_clk) soft_i <= 1'b1;
    @(posedge sys_clk) soft_i <= 1'b0;
    wait_take();
    chk({stk, 5'h00, vsel}, {1'b0, 5'h00, SECLP_VEC_SWI});
    mask <= 1'b0;
    @(posedge sys_clk);
    irq <= 1'b1;
    iend <= 1'b1;
    @(posedge sys_clk) iend <= 1'b0;
    wait_take();
    irq <= 1'b0;
    chk({stk, 5'h00, vsel}, {1'b1, 5'h00, SECLP_VEC_HW});
    $display("Exception test done");
    for (int w = 0; w < 2; w++) begin
      c0 = cm_cnt;
      @(posedge sys_clk) wait_i <= 1'b1;
      @(posedge sys_clk) wait_i <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({cpu_en, per_en, wd_run, 5'h00}, 8'h60);
      chk(8'(cm_cnt - c0), 8'h01);
      irq <= (w == 0);
      brk <= (w == 1);
      wait_take();
      irq <= 1'b0;
      brk <= 1'b0;
      chk(8'(k), w ? 8'h04 : 8'h02);
    end
    chk({stk, 5'h00, vsel}, {1'b0, 5'h00, SECLP_VEC_SWI});
    @(posedge sys_clk) pset <= 1'b1;
    @(posedge sys_clk) pset <= 1'b0;
    bws = 2;
    rd(SECLP_ADDR_BWS);
    for (int j = 0; j < 2; j++) begin
      wr(SECLP_ADDR_BFCC, j ? 8'h80 : 8'h00);
      @(posedge sys_clk) creq <= 1'b1;
      @(posedge sys_clk) creq <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({7'h00, pflag}, j ? 8'h00 : 8'h01);
    end
    @(posedge sys_clk) bexit <= 1'b1;
    @(posedge sys_clk) bexit <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({inb, pflag, 6'h00}, 8'h00);
    wr(SECLP_ADDR_BWS, 8'h00);
    rd(SECLP_ADDR_BWS);
    $display("Wait and break test done");
    for (int s = 1; s >= 0; s--) begin
      ssr <= s[0];
      @(posedge sys_clk) halt_i <= 1'b1;
      @(posedge sys_clk) halt_i <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({base_en, xo_en, brk_en, 5'h00}, 8'h00);
      irq <= 1'b1;
      wait_take();
      irq <= 1'b0;
      c0 = s ? 80 : 10240;
      chk(8'(k >= c0 - 3 && k < c0 + 20), 8'h01);
    end
    $display("Stop test done");
    give_verdict();
  end
endmodule
`default_nettype wire
